/* hdl/scb_config_bank.sv */
// Sensor configuration register bank with frame-boundary shadowing
`timescale 1ns/100ps
module scb_config_bank
   import scb_pkg::*;
(
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Internal register bus from the serial slave
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   output logic             o_reg_rvalid,
   output scb_blk_t         o_blk_sel,
   // Sensor timing side
   input  wire logic        i_frame_bound,
   input  wire logic [5:0]  i_coef_idx,
   output logic      [7:0]  o_coef_data,
   output scb_cfg_t         o_cfg
);

   logic [7:0]           staged_q [SCB_NREG];
   logic [7:0]           act_q    [SCB_NREG];
   logic [7:0]           coef_q   [SCB_NCOEF];
   logic [SCB_NREG-1:0]  hit;
   logic [SCB_NREG*8-1:0] act_flat;
   logic [7:0]           tbl_rdata;
   logic                 coef_hit;
   logic                 any_hit;
   scb_blk_t             blk_d;
   logic [7:0]           rdata_d;
   logic [7:0]           ana_rdata;
   logic [7:0]           sen_rdata;
   logic [7:0]           col_rdata;

   // Address decode into blocks
   always_comb begin
      if (i_reg_addr[7:4] >= SCB_GRP_ANA_LO && i_reg_addr[7:4] <= SCB_GRP_ANA_HI) begin // R01 R03
         blk_d = SCB_BLK_ANA;
      end else if (i_reg_addr[7:4] >= SCB_GRP_SEN_LO
                   && i_reg_addr[7:4] <= SCB_GRP_SEN_HI) begin // R03
         blk_d = SCB_BLK_SEN;
      end else if (i_reg_addr[7:6] == SCB_COEF_TOP) begin // R03
         blk_d = SCB_BLK_COEF;
      end else begin
         blk_d = SCB_BLK_NONE;
      end
   end

   assign coef_hit = (blk_d == SCB_BLK_COEF);

   // Per register storage, shadow and output packing
   genvar g;
   generate
      for (g = 0; g < SCB_NREG; g++) begin : g_reg
         assign hit[g] = (i_reg_addr == SCB_ADDR[g]);
         assign act_flat[(SCB_NREG-1-g)*8 +: 8] = act_q[g];

         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               staged_q[g] <= SCB_RST[g]; // R06 R07 R08 R10 R11 R12 R13 R15 R16 R17
            end else if (i_reg_wr && hit[g]) begin
               staged_q[g] <= i_reg_wdata; // R04
            end
         end

         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               act_q[g] <= SCB_RST[g];
            end else if (SCB_SHADOW[g]) begin
               if (i_frame_bound) begin
                  act_q[g] <= staged_q[g]; // R05 R14
               end
            end else if (i_reg_wr && hit[g]) begin
               act_q[g] <= i_reg_wdata; // R07 R08 R12
            end
         end

         a_reg_reset: assert property (@(posedge i_sys_clk) // R06 R07 R08 R10 R11 R12 R13
            $past(i_rst) && !i_rst
            |-> act_q[g] == SCB_RST[g] && staged_q[g] == SCB_RST[g])
            else $error("register reset value wrong");

         a_stage_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
            i_reg_wr && i_reg_addr == SCB_ADDR[g] |=> staged_q[g] == $past(i_reg_wdata))
            else $error("write did not reach register");

         if (SCB_SHADOW[g]) begin : g_shadow
            a_shadow_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
               !i_frame_bound |=> $stable(act_q[g]))
               else $error("shadowed register changed inside frame");

            a_shadow_load: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
               i_frame_bound |=> act_q[g] == $past(staged_q[g]))
               else $error("shadowed register missed frame boundary");
         end else begin : g_direct
            a_direct_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
               i_reg_wr && i_reg_addr == SCB_ADDR[g] |=> act_q[g] == $past(i_reg_wdata))
               else $error("unshadowed register did not follow write");
         end
      end
   endgenerate

   assign any_hit = |hit;
   assign o_cfg   = scb_cfg_t'(act_flat);

   // Read mux of table registers
   always_comb begin
      tbl_rdata = 8'h00;
      for (int i = 0; i < SCB_NREG; i++) begin
         if (hit[i]) begin
            tbl_rdata = staged_q[i];
         end
      end
   end

   // Each block drives the shared read bus only inside its own range
   always_comb begin
      ana_rdata = 8'h00;
      if (blk_d == SCB_BLK_ANA) begin
         if (i_reg_addr == SCB_ADDR_IDENT) begin
            ana_rdata = SCB_DEV_IDENT; // R09
         end else begin
            ana_rdata = tbl_rdata; // R04
         end
      end
   end

   always_comb begin
      sen_rdata = 8'h00;
      if (blk_d == SCB_BLK_SEN) begin
         sen_rdata = tbl_rdata; // R04
      end
   end

   always_comb begin
      col_rdata = 8'h00;
      if (coef_hit) begin
         col_rdata = coef_q[i_reg_addr[5:0]]; // R03
      end
   end

   // Unused addresses leave every block silent and read zero
   assign rdata_d = ana_rdata | sen_rdata | col_rdata; // R02 R20

   // Column offset coefficients
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         for (int i = 0; i < SCB_NCOEF; i++) begin
            coef_q[i] <= SCB_COEF_RST;
         end
      end else if (i_reg_wr && coef_hit) begin
         coef_q[i_reg_addr[5:0]] <= i_reg_wdata; // R03 R04
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_coef_data <= 8'h00;
      end else begin
         o_coef_data <= coef_q[i_coef_idx]; // R04
      end
   end

   // Read answer and block select
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd; // R19
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_blk_sel <= SCB_BLK_NONE;
      end else if (i_reg_rd || i_reg_wr) begin
         o_blk_sel <= blk_d; // R02
      end else begin
         o_blk_sel <= SCB_BLK_NONE;
      end
   end

   a_unused_read_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R20
      i_reg_rd && (i_reg_addr == 8'h04 || i_reg_addr == 8'h3C || i_reg_addr >= 8'hC0)
      |=> o_reg_rvalid && o_reg_rdata == 8'h00)
      else $error("unused address did not read zero");

   a_ident_read_only: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R09
      i_reg_rd && i_reg_addr == SCB_ADDR_IDENT |=> o_reg_rdata == SCB_DEV_IDENT)
      else $error("identification read wrong");

   a_shadow_gain_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
      !i_frame_bound |=> $stable(o_cfg.digital_color_gain) && $stable(o_cfg.capture_mode))
      else $error("shadowed value changed inside frame");

   a_shadow_frame_load: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
      i_frame_bound |=> act_q[SCB_IDX_CAPTURE] == $past(staged_q[SCB_IDX_CAPTURE]))
      else $error("shadowed value not loaded at frame boundary");

   a_vref_direct: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R08
      i_reg_wr && i_reg_addr == SCB_ADDR[SCB_IDX_NEG_VREF]
      |=> o_cfg.neg_vref == $past(i_reg_wdata))
      else $error("unshadowed register did not follow write");

   a_reset_values: assert property (@(posedge i_sys_clk) // R06 R15 R16 R17
      $past(i_rst) && !i_rst |-> o_cfg.digital_color_gain[3] == 8'h0E
      && o_cfg.readout_window_row_depth == 16'h03FF
      && o_cfg.readout_window_col_width == 16'h04FF
      && o_cfg.integration_time == 16'h04FF && o_cfg.frame_row_depth == 16'h0427
      && o_cfg.tristate_ctrl == 8'h03 && o_cfg.capture_mode == 8'h2A)
      else $error("reset value wrong");

   a_block_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R02 R03
      (i_reg_rd || i_reg_wr) && i_reg_addr[7:6] == 2'b01 |=> o_blk_sel == SCB_BLK_SEN)
      else $error("sensor block not selected");

   a_tile_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
      (i_reg_wr && i_reg_addr == SCB_ADDR[SCB_IDX_TILE_CFG])
      ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == SCB_ADDR[SCB_IDX_TILE_CFG])
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("tile configuration readback wrong");

   a_coef_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R03
      (i_reg_wr && i_reg_addr == 8'h85) ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h85)
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("column coefficient readback wrong");

   a_reset_gains: assert property (@(posedge i_sys_clk) // R06 R10
      $past(i_rst) && !i_rst
      |-> o_cfg.digital_color_gain == {4{8'h0E}}
      && o_cfg.exposure_gain_a == 8'h0E
      && o_cfg.exposure_gain_b == 8'h0E)
      else $error("gain reset value wrong");

   a_reset_tiles: assert property (@(posedge i_sys_clk) // R07
      $past(i_rst) && !i_rst
      |-> o_cfg.tile_cfg == 8'h05
      && o_cfg.tile_row == {8'h44, 8'hEE, 8'h00, 8'h00})
      else $error("tile reset value wrong");

   a_reset_vref: assert property (@(posedge i_sys_clk) // R08
      $past(i_rst) && !i_rst
      |-> o_cfg.neg_vref == 8'h76
      && o_cfg.pos_vref == 8'h80)
      else $error("reference code reset value wrong");

   a_reset_drive_bias: assert property (@(posedge i_sys_clk) // R11
      $past(i_rst) && !i_rst
      |-> o_cfg.tristate_ctrl == 8'h03
      && o_cfg.bias_ctrl == 8'h00)
      else $error("tristate or bias reset value wrong");

   a_reset_offsets: assert property (@(posedge i_sys_clk) // R12
      $past(i_rst) && !i_rst
      |-> o_cfg.offset_voltage_adjust_dc == 8'h00
      && o_cfg.gain_mode == 8'h00
      && o_cfg.global_offset_voltage_adjust == 8'h00)
      else $error("offset reset value wrong");

   a_reset_capture: assert property (@(posedge i_sys_clk) // R13
      $past(i_rst) && !i_rst
      |-> o_cfg.capture_mode == 8'h2A
      && o_cfg.subsample == 8'h10
      && o_cfg.sync_strobe == 8'h02)
      else $error("capture reset value wrong");

   a_reset_window: assert property (@(posedge i_sys_clk) // R14 R15
      $past(i_rst) && !i_rst
      |-> o_cfg.readout_window_row_start == 16'h0010
      && o_cfg.readout_window_row_depth == 16'h03FF
      && o_cfg.readout_window_col_start == 16'h0008
      && o_cfg.readout_window_col_width == 16'h04FF)
      else $error("window reset value wrong");

   a_reset_outputs: assert property (@(posedge i_sys_clk) // R04
      $past(i_rst) && !i_rst
      |-> o_reg_rdata == 8'h00
      && !o_reg_rvalid
      && o_blk_sel == SCB_BLK_NONE
      && o_coef_data == 8'h00)
      else $error("output reset value wrong");

   a_rvalid_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R19
      i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");

   a_rvalid_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R19
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("read answer without read");

   a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
      !i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without read");

   a_analog_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R03
      (i_reg_rd || i_reg_wr) && i_reg_addr <= 8'h2F
      |=> o_blk_sel == SCB_BLK_ANA)
      else $error("analog block not selected");

   a_group_uniform: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R01
      (i_reg_rd || i_reg_wr) && i_reg_addr[7:4] == 4'h1
      |=> o_blk_sel == SCB_BLK_ANA)
      else $error("group of sixteen split between blocks");

   a_coef_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R03
      (i_reg_rd || i_reg_wr) && i_reg_addr[7:6] == 2'b10
      |=> o_blk_sel == SCB_BLK_COEF)
      else $error("coefficient block not selected");

   a_none_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R01 R03
      (i_reg_rd || i_reg_wr) && (i_reg_addr[7:4] == 4'h3 || i_reg_addr[7:6] == 2'b11)
      |=> o_blk_sel == SCB_BLK_NONE)
      else $error("unowned range selected a block");

   a_blk_access: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R03
      (i_reg_rd || i_reg_wr) && i_reg_addr[7:4] != 4'h3 && i_reg_addr[7:6] != 2'b11
      |=> o_blk_sel != SCB_BLK_NONE)
      else $error("owned range selected no block");

   a_idle_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R02
      !(i_reg_rd || i_reg_wr) |=> o_blk_sel == SCB_BLK_NONE)
      else $error("block selected without access");

   a_ident_write_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R09
      i_reg_wr && !i_frame_bound && i_reg_addr == SCB_ADDR_IDENT
      |=> $stable(o_cfg))
      else $error("identification write changed configuration");

   a_unused_write_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R20
      i_reg_wr && !i_frame_bound && (i_reg_addr == 8'h04 || i_reg_addr == 8'h11
      || i_reg_addr[7:4] == 4'h3 || (i_reg_addr >= 8'h52 && i_reg_addr <= 8'h7F)
      || i_reg_addr >= 8'hC0) |=> $stable(o_cfg))
      else $error("unused write changed configuration");

   a_unused_silent: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R20
      i_reg_rd && !any_hit && !coef_hit && i_reg_addr != SCB_ADDR_IDENT
      |=> o_reg_rdata == 8'h00)
      else $error("unimplemented address drove read bus");

   a_coef_write_isolated: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R02
      i_reg_wr && !i_frame_bound && i_reg_addr[7:6] == SCB_COEF_TOP
      |=> $stable(o_cfg))
      else $error("coefficient write changed configuration");

   a_sensor_write_isolated: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R02
      i_reg_wr && i_reg_addr[7:6] == 2'b01
      |=> $stable(o_cfg.tile_cfg) && $stable(o_cfg.neg_vref)
      && $stable(o_cfg.pos_vref) && $stable(o_cfg.gain_mode))
      else $error("sensor write changed analog register");

   a_read_no_effect: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
      i_reg_rd && !i_reg_wr && !i_frame_bound
      |=> $stable(o_cfg))
      else $error("read changed configuration");

   a_tile_direct: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R07
      i_reg_wr && i_reg_addr == SCB_ADDR[SCB_IDX_TILE_CFG]
      |=> o_cfg.tile_cfg == $past(i_reg_wdata))
      else $error("tile configuration did not follow write");

   a_frame_no_direct: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
      i_frame_bound && !i_reg_wr
      |=> $stable(o_cfg.tile_cfg) && $stable(o_cfg.neg_vref) && $stable(o_cfg.gain_mode))
      else $error("frame boundary changed unshadowed register");

   a_shadow_deferred: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
      i_reg_wr && !i_frame_bound && i_reg_addr == SCB_ADDR[SCB_IDX_CAPTURE]
      |=> $stable(o_cfg.capture_mode))
      else $error("shadowed write took effect inside frame");

endmodule : scb_config_bank

/* hdl/scb_pkg.sv */
// Constants, register table and carrier types for the sensor configuration bank
// Function
// R01 - Register space split into groups of sixteen
// R02 - Only the addressed block drives control bus
// R03 - Decode 00-2F analog, 40-7F sensor, 80-BF column
// R04 - Registers writable, readable, and feed sensor logic
// R05 - Shadowed values take effect at frame boundary
// R06 - Four colour gains reset 0x0E, shadowed
// R07 - Tile config and rows reset, unshadowed
// R08 - Voltage reference codes reset 0x76/0x80, unshadowed
// R09 - Address 0x0F read-only identification value
// R10 - Exposure gains A/B reset 0x0E, shadowed
// R11 - Tristate resets 0x03, bias resets 0x00
// R12 - Offset DC, gain mode, global offset zero
// R13 - Capture, subsample, sync registers reset, shadowed
// R14 - Window values split hi/lo bytes, shadowed
// R15 - Window reset values 0010/03FF/0008/04FF
// R16 - Integration time two bytes, reset 04FF, shadowed
// R17 - Frame row depth two bytes, reset 0427
// R18 - Master uses calling bytes 0x66/0x67
// R19 - Read: address, restart, one byte, NAK, stop
// R20 - Unused addresses read zero, writes ignored
// R21 - Master avoids factory reserved addresses
package scb_pkg;

   localparam int SCB_NREG = 35;

   // Block groups by address bits [7:4], column block by address bits [7:6]
   localparam logic [3:0] SCB_GRP_ANA_LO = 4'h0;
   localparam logic [3:0] SCB_GRP_ANA_HI = 4'h2;
   localparam logic [3:0] SCB_GRP_SEN_LO = 4'h4;
   localparam logic [3:0] SCB_GRP_SEN_HI = 4'h7;
   localparam logic [1:0] SCB_COEF_TOP   = 2'h2;
   localparam int         SCB_NCOEF      = 64;

   localparam logic [7:0] SCB_ADDR_IDENT = 8'h0F;
   // Identification value: arbitrary
   localparam logic [7:0] SCB_DEV_IDENT  = 8'hA5;
   localparam logic [7:0] SCB_COEF_RST   = 8'h00;

   // Table indices used outside the table
   localparam int SCB_IDX_GAIN1    = 0;
   localparam int SCB_IDX_TILE_CFG = 4;
   localparam int SCB_IDX_NEG_VREF = 9;
   localparam int SCB_IDX_CAPTURE  = 20;

   localparam logic [7:0] SCB_ADDR [SCB_NREG] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h13, 8'h20, 8'h21,
      8'h22, 8'h23, 8'h40, 8'h41, 8'h42, 8'h45, 8'h46, 8'h47, 8'h48,
      8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4E, 8'h4F, 8'h50, 8'h51};

   localparam logic [7:0] SCB_RST [SCB_NREG] = '{
      8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h05, 8'h44, 8'hEE, 8'h00, 8'h00,
      8'h76, 8'h80, 8'h00, 8'h00, 8'h0E, 8'h03, 8'h00, 8'h00, 8'h0E,
      8'h00, 8'h00, 8'h2A, 8'h10, 8'h02, 8'h00, 8'h10, 8'h03, 8'hFF,
      8'h00, 8'h08, 8'h04, 8'hFF, 8'h04, 8'hFF, 8'h04, 8'h27};

   localparam logic SCB_SHADOW [SCB_NREG] = '{
      1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
      1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
      1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

   typedef enum logic [1:0] {
      SCB_BLK_NONE = 2'b00,
      SCB_BLK_ANA  = 2'b01,
      SCB_BLK_SEN  = 2'b10,
      SCB_BLK_COEF = 2'b11
   } scb_blk_t;

   // Field order follows table order, first entry in the top byte
   typedef struct packed {
      logic [3:0][7:0] digital_color_gain;
      logic [7:0]      tile_cfg;
      logic [3:0][7:0] tile_row;
      logic [7:0]      neg_vref;
      logic [7:0]      pos_vref;
      logic [7:0]      power_cfg;
      logic [7:0]      reset_ctrl;
      logic [7:0]      exposure_gain_a;
      logic [7:0]      tristate_ctrl;
      logic [7:0]      bias_ctrl;
      logic [7:0]      offset_voltage_adjust_dc;
      logic [7:0]      exposure_gain_b;
      logic [7:0]      gain_mode;
      logic [7:0]      global_offset_voltage_adjust;
      logic [7:0]      capture_mode;
      logic [7:0]      subsample;
      logic [7:0]      sync_strobe;
      logic [15:0]     readout_window_row_start;
      logic [15:0]     readout_window_row_depth;
      logic [15:0]     readout_window_col_start;
      logic [15:0]     readout_window_col_width;
      logic [15:0]     integration_time;
      logic [15:0]     frame_row_depth;
   } scb_cfg_t;

endpackage : scb_pkg

/* bench/scb_host_model.sv */
// Partner model: serial slave front end issuing register bus accesses
`timescale 1ns/100ps
module scb_host_model (
   // Clock
   input  wire logic       i_sys_clk,
   // Register bus toward the bank
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_rd
);
   initial begin
      o_reg_addr  = 8'h00;
      o_reg_wr    = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd    = 1'b0;
   end

   // Address with data, one byte per write, bus inverted when released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      o_reg_wr    <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b0;
      o_reg_addr  <= ~a;
      o_reg_wdata <= ~d;
   endtask : wr

   // One byte per read
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      o_reg_addr <= a;
      o_reg_rd   <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_rd   <= 1'b0;
      o_reg_addr <= ~a;
   endtask : rd

   // Write then read back at the very next edge
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      o_reg_wr    <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_rd    <= 1'b0;
      o_reg_addr  <= ~a;
      o_reg_wdata <= ~d;
   endtask : wr_rd
endmodule : scb_host_model

/* bench/testbench.sv */
// Self-checking testbench for the sensor configuration bank
`timescale 1ns/100ps
module testbench;
   import scb_pkg::*;
   logic            i_sys_clk = 1'b0;
   logic            i_rst;
   logic            i_frame_bound;
   logic      [5:0] i_coef_idx;
   logic      [7:0] addr, wdata, rdata, coef, v;
   logic            wr, rd, rvalid;
   scb_blk_t        blk;
   scb_cfg_t        cfg;
   logic      [7:0] exp_q[$];
   logic      [7:0] unused[6] = '{8'h04, 8'h11, 8'h30, 8'h52, 8'hC0, 8'hFF};
   logic     [31:0] seed = 32'd87;
   int              fails = 0;
   int              tests_run = 0;

   always #10 i_sys_clk = ~i_sys_clk;

   scb_host_model u_host (.i_sys_clk(i_sys_clk), .o_reg_addr(addr), .o_reg_wr(wr),
      .o_reg_wdata(wdata), .o_reg_rd(rd));
   scb_config_bank u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .o_blk_sel(blk), .i_frame_bound(i_frame_bound),
      .i_coef_idx(i_coef_idx), .o_coef_data(coef), .o_cfg(cfg));

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      if (exp_q.size() != 0) fails++;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   // Read data checked against the oldest note
   always @(posedge i_sys_clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("[FAIL] %0t unexpected read data", $time);
         end else
            chk(16'(rdata), 16'(exp_q.pop_front()));
      end
   end

   initial begin
      repeat (3000) @(posedge i_sys_clk);
      fails++;
      conclude();
   end

   initial begin
      i_rst = 1'b1;
      i_frame_bound = 1'b0;
      i_coef_idx = 6'h00;
      repeat (8) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < SCB_NREG; i++) begin
         exp_q.push_back(SCB_RST[i]);
         u_host.rd(SCB_ADDR[i]);
      end
      #1;
      chk(cfg.readout_window_row_start, 16'h0010);
      chk(cfg.readout_window_col_width, 16'h04FF);
      chk(cfg.integration_time, 16'h04FF);
      chk(cfg.frame_row_depth, 16'h0427);
      u_host.wr(SCB_ADDR_IDENT, rnd());
      exp_q.push_back(SCB_DEV_IDENT);
      u_host.rd(SCB_ADDR_IDENT);
      foreach (unused[k]) begin
         u_host.wr(unused[k], rnd());
         exp_q.push_back(8'h00);
         u_host.rd(unused[k]);
      end
      exp_q.push_back(8'h05);
      u_host.rd(8'h05);
      v = rnd();
      exp_q.push_back(v);
      u_host.wr_rd(SCB_ADDR[SCB_IDX_TILE_CFG], v);
      #1;
      chk(16'(cfg.tile_cfg), 16'(v));
      v = rnd();
      u_host.wr(8'h0A, v);
      #1;
      chk(cfg.neg_vref, 16'(v));
      chk(16'(blk), 16'(SCB_BLK_ANA));
      v = rnd();
      u_host.wr(8'h40, v);
      #1;
      chk(16'(blk), 16'(SCB_BLK_SEN));
      chk(16'(cfg.capture_mode), 16'h002A);
      exp_q.push_back(v);
      u_host.rd(8'h40);
      @(posedge i_sys_clk) i_frame_bound <= 1'b1;
      @(posedge i_sys_clk) i_frame_bound <= 1'b0;
      #1;
      chk(16'(cfg.capture_mode), 16'(v));
      v = rnd();
      exp_q.push_back(v);
      u_host.wr_rd(8'h85, v);
      i_coef_idx <= 6'h05;
      #1;
      chk(16'(blk), 16'(SCB_BLK_COEF));
      @(posedge i_sys_clk);
      #1;
      chk(16'(coef), 16'(v));
      repeat (3) @(posedge i_sys_clk);
      conclude();
   end
endmodule : testbench
